// ### hdl/cgs_clock_gate.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// R1: the upper sleep enable register holds fifteen rw bits 14..0 resetting to 1, 31..15 reserved.
// R2: the lower status word shows which first-group branch enables are asserted, 0 after reset.
// R3: the upper status word shows second-group branch enables in bits 14..0, 0 after reset.
// R4: masked status bit 0 is the raw resuscitation event anded with enable bit 0, both reset 0.
// R5: force bit 0 sets the masked status regardless of raw or enable, force resets to 0.
// R6: wake enable registers hold one bit per branch clock, resetting to 1.
// R7: each branch enable follows wake bits while awake and sleep bits while asleep, as reported.
module cgs_clock_gate (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [cgs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [cgs_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [cgs_pkg::DATA_W-1:0] RDATA,
    input wire logic SLEEPING,
    input wire logic RESUS_EVENT,
    output logic [cgs_pkg::LO_W-1:0] BRANCH_EN_LO,
    output logic [cgs_pkg::HI_W-1:0] BRANCH_EN_HI,
    output logic RESUS_IRQ
);
    import cgs_pkg::*;

    logic [LO_W-1:0] wake_lo_q;
    logic [LO_W-1:0] wake_lo_d;
    logic [HI_W-1:0] wake_hi_q;
    logic [HI_W-1:0] wake_hi_d;
    logic [LO_W-1:0] sleep_lo_q;
    logic [LO_W-1:0] sleep_lo_d;
    logic [HI_W-1:0] sleep_hi_q;
    logic [HI_W-1:0] sleep_hi_d;
    logic interrupt_mask_enable_q;
    logic interrupt_mask_enable_d;
    logic interrupt_force_q;
    logic interrupt_force_d;
    logic raw_q;
    logic raw_d;
    logic interrupt_masked_status_q;
    logic interrupt_masked_status_d;
    logic [LO_W-1:0] stat_lo_q;
    logic [LO_W-1:0] stat_lo_d;
    logic [HI_W-1:0] stat_hi_q;
    logic [HI_W-1:0] stat_hi_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic wr_wake_lo;
    logic wr_wake_hi;
    logic wr_sleep_lo;
    logic wr_sleep_hi;
    logic wr_interrupt_mask_enable;
    logic wr_interrupt_force;
    logic rd_wake_lo;
    logic rd_wake_hi;
    logic rd_sleep_lo;
    logic rd_sleep_hi;
    logic rd_stat_lo;
    logic rd_stat_hi;
    logic rd_raw;
    logic rd_interrupt_mask_enable;
    logic rd_interrupt_force;
    logic rd_interrupt_masked_status;

    // one compare per register strobe, shared by write and read decode
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off);
        hit = strobe && (addr == off);
    endfunction

    function automatic logic [DATA_W-1:0] pad_hi(input logic [HI_W-1:0] v);
        pad_hi = {{(DATA_W-HI_W){1'b0}}, v};
    endfunction

    function automatic logic [DATA_W-1:0] pad_bit(input logic v);
        pad_bit = {{(DATA_W-1){1'b0}}, v};
    endfunction

    always_comb begin
        wr_wake_lo = hit(WR, ADDR, OFF_WAKE_LO);
        wr_wake_hi = hit(WR, ADDR, OFF_WAKE_HI);
        wr_sleep_lo = hit(WR, ADDR, OFF_SLEEP_LO);
        wr_sleep_hi = hit(WR, ADDR, OFF_SLEEP_HI);
        wr_interrupt_mask_enable = hit(WR, ADDR, OFF_INTERRUPT_MASK_ENABLE);
        wr_interrupt_force = hit(WR, ADDR, OFF_INTERRUPT_FORCE);
        rd_wake_lo = hit(RD, ADDR, OFF_WAKE_LO);
        rd_wake_hi = hit(RD, ADDR, OFF_WAKE_HI);
        rd_sleep_lo = hit(RD, ADDR, OFF_SLEEP_LO);
        rd_sleep_hi = hit(RD, ADDR, OFF_SLEEP_HI);
        rd_stat_lo = hit(RD, ADDR, OFF_STAT_LO);
        rd_stat_hi = hit(RD, ADDR, OFF_STAT_HI);
        rd_raw = hit(RD, ADDR, OFF_RAW);
        rd_interrupt_mask_enable = hit(RD, ADDR, OFF_INTERRUPT_MASK_ENABLE);
        rd_interrupt_force = hit(RD, ADDR, OFF_INTERRUPT_FORCE);
        rd_interrupt_masked_status = hit(RD, ADDR, OFF_INTERRUPT_MASKED_STATUS);
    end

    // wake enables pick the running branches while awake
    always_comb begin
        wake_lo_d = wake_lo_q;
        if (wr_wake_lo) begin
            wake_lo_d = WDATA[LO_W-1:0]; // R6
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_lo_q <= RST_EN_LO; // R6
        end else if (CE) begin
            wake_lo_q <= wake_lo_d;
        end
    end

    always_comb begin
        wake_hi_d = wake_hi_q;
        if (wr_wake_hi) begin
            wake_hi_d = WDATA[HI_W-1:0]; // R6
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_hi_q <= RST_EN_HI; // R6
        end else if (CE) begin
            wake_hi_q <= wake_hi_d;
        end
    end

    always_comb begin
        sleep_lo_d = sleep_lo_q;
        if (wr_sleep_lo) begin
            sleep_lo_d = WDATA[LO_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sleep_lo_q <= RST_EN_LO;
        end else if (CE) begin
            sleep_lo_q <= sleep_lo_d;
        end
    end

    always_comb begin
        sleep_hi_d = sleep_hi_q;
        if (wr_sleep_hi) begin
            sleep_hi_d = WDATA[HI_W-1:0]; // R1
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            sleep_hi_q <= RST_EN_HI; // R1
        end else if (CE) begin
            sleep_hi_q <= sleep_hi_d;
        end
    end

    always_comb begin
        interrupt_mask_enable_d = interrupt_mask_enable_q;
        if (wr_interrupt_mask_enable) begin
            interrupt_mask_enable_d = WDATA[RESUS_BIT]; // R4
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_mask_enable_q <= 1'b0; // R4
        end else if (CE) begin
            interrupt_mask_enable_q <= interrupt_mask_enable_d;
        end
    end

    always_comb begin
        interrupt_force_d = interrupt_force_q;
        if (wr_interrupt_force) begin
            interrupt_force_d = WDATA[RESUS_BIT]; // R5
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_force_q <= 1'b0; // R5
        end else if (CE) begin
            interrupt_force_q <= interrupt_force_d;
        end
    end

    // raw bit not sticky; the detector holds its event
    always_comb begin
        raw_d = RESUS_EVENT;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            raw_q <= 1'b0;
        end else if (CE) begin
            raw_q <= raw_d;
        end
    end

    // force wins over the mask so software can test the path
    always_comb begin
        interrupt_masked_status_d = 1'b0;
        if (interrupt_force_q) begin
            interrupt_masked_status_d = 1'b1; // R5
        end else if (raw_q && interrupt_mask_enable_q) begin
            interrupt_masked_status_d = 1'b1; // R4
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_masked_status_q <= 1'b0;
        end else if (CE) begin
            interrupt_masked_status_q <= interrupt_masked_status_d;
        end
    end

    // status lags the enable registers by one cycle, same as the branch outputs
    always_comb begin
        if (SLEEPING) begin
            stat_lo_d = sleep_lo_q; // R7 R2
        end else begin
            stat_lo_d = wake_lo_q; // R7 R2
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            stat_lo_q <= RST_STAT_LO; // R2
        end else if (CE) begin
            stat_lo_q <= stat_lo_d;
        end
    end

    always_comb begin
        if (SLEEPING) begin
            stat_hi_d = sleep_hi_q; // R7 R3
        end else begin
            stat_hi_d = wake_hi_q; // R7 R3
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            stat_hi_q <= RST_STAT_HI; // R3
        end else if (CE) begin
            stat_hi_q <= stat_hi_d;
        end
    end

    // unmapped offsets read 0; nothing is held after the read cycle unless ce is low
    always_comb begin
        rdata_d = '0;
        if (rd_wake_lo) begin
            rdata_d = wake_lo_q;
        end
        if (rd_wake_hi) begin
            rdata_d = pad_hi(wake_hi_q);
        end
        if (rd_sleep_lo) begin
            rdata_d = sleep_lo_q;
        end
        if (rd_sleep_hi) begin
            rdata_d = pad_hi(sleep_hi_q); // R1
        end
        if (rd_stat_lo) begin
            rdata_d = stat_lo_q; // R2
        end
        if (rd_stat_hi) begin
            rdata_d = pad_hi(stat_hi_q); // R3
        end
        if (rd_raw) begin
            rdata_d = pad_bit(raw_q);
        end
        if (rd_interrupt_mask_enable) begin
            rdata_d = pad_bit(interrupt_mask_enable_q);
        end
        if (rd_interrupt_force) begin
            rdata_d = pad_bit(interrupt_force_q);
        end
        if (rd_interrupt_masked_status) begin
            rdata_d = pad_bit(interrupt_masked_status_q); // R4
        end
    end

    // ce low freezes every register, read data included
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= '0;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;
    assign BRANCH_EN_LO = stat_lo_q; // R7
    assign BRANCH_EN_HI = stat_hi_q;
    assign RESUS_IRQ = interrupt_masked_status_q;
endmodule

// ### hdl/cgs_pkg.sv
package cgs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LO_W = 32;
    localparam int HI_W = 15;

    localparam logic [ADDR_W-1:0] OFF_WAKE_LO = 8'ha0;
    localparam logic [ADDR_W-1:0] OFF_WAKE_HI = 8'ha4;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_LO = 8'ha8;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_HI = 8'hac;
    localparam logic [ADDR_W-1:0] OFF_STAT_LO = 8'hb0;
    localparam logic [ADDR_W-1:0] OFF_STAT_HI = 8'hb4;
    localparam logic [ADDR_W-1:0] OFF_RAW = 8'hb8;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_MASK_ENABLE = 8'hbc;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_FORCE = 8'hc0;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_MASKED_STATUS = 8'hc4;

    localparam logic [LO_W-1:0] RST_EN_LO = 32'hffffffff;
    localparam logic [HI_W-1:0] RST_EN_HI = 15'h7fff;
    localparam logic [LO_W-1:0] RST_STAT_LO = 32'h00000000;
    localparam logic [HI_W-1:0] RST_STAT_HI = 15'h0000;
    localparam int RESUS_BIT = 0;
endpackage

// ### tb/cgs_properties.sv
`timescale 1ns/1ps
module cgs_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [cgs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [cgs_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [cgs_pkg::DATA_W-1:0] RDATA,
    input wire logic SLEEPING,
    input wire logic [cgs_pkg::LO_W-1:0] BRANCH_EN_LO,
    input wire logic [cgs_pkg::HI_W-1:0] BRANCH_EN_HI,
    input wire logic RESUS_IRQ
);
    import cgs_pkg::*;
    default clocking @(posedge CLK); endclocking
    // frozen cycles stretch every timing below, so they drop the attempt
    default disable iff (RST || !CE);
    a_sleep_rsvd: assert property (RD && ADDR == OFF_SLEEP_HI |=> RDATA[31:15] == 17'h0)
        else $error("sleep hi reserved bits set");
    a_stat_lo: assert property (RD && ADDR == OFF_STAT_LO |=> RDATA == $past(BRANCH_EN_LO))
        else $error("status lo differs from enables");
    a_stat_hi: assert property (RD && ADDR == OFF_STAT_HI |=> RDATA == {17'h0, $past(BRANCH_EN_HI)})
        else $error("status hi differs from enables");
    a_interrupt_masked_status_read: assert property (RD && ADDR == OFF_INTERRUPT_MASKED_STATUS |=> RDATA == {31'h0, $past(RESUS_IRQ)})
        else $error("masked status read wrong");
    a_force_irq: assert property (WR && ADDR == OFF_INTERRUPT_FORCE && WDATA[0] |-> ##2 RESUS_IRQ)
        else $error("force did not raise irq");
    a_wake_reset: assert property ($fell(RST) && !SLEEPING |=> BRANCH_EN_LO == RST_EN_LO && BRANCH_EN_HI == RST_EN_HI)
        else $error("wake enables not applied after reset");
    a_sleep_follow: assert property ((WR && ADDR == OFF_SLEEP_HI && SLEEPING) ##1 (SLEEPING && !WR) |=> BRANCH_EN_HI == $past(WDATA[14:0], 2))
        else $error("branch hi not from sleep bits");
    cover property (WR && ADDR == OFF_INTERRUPT_FORCE && WDATA[0]);
    cover property (RD && ADDR == OFF_STAT_HI && SLEEPING);
    cover property ($fell(RST));
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cgs_pkg::*;
    logic CLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, SLEEPING = 0, RESUS_EVENT = 0;
    logic [7:0] ADDR = 8'h0;
    logic [31:0] WDATA = 32'h0, RDATA, s = 32'h7aee1ec2, r, q;
    logic [31:0] BLO;
    logic [14:0] BHI;
    logic IRQ;
    int fail_count = 0, compares = 0;
    always #12.5 CLK = ~CLK;
    cgs_clock_gate cgs_clock_gate_i (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEPING(SLEEPING), .RESUS_EVENT(RESUS_EVENT),
        .BRANCH_EN_LO(BLO), .BRANCH_EN_HI(BHI), .RESUS_IRQ(IRQ));
    function logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function logic exp_irq(input logic [2:0] i);
        return (i[0] & i[2]) | i[1];
    endfunction
    task stop_test;
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // outputs looked at off the edge, then back on an edge for the next drive
    task outs(input logic [31:0] lo, input logic [14:0] hi, input logic irq);
        #1;
        check("branch_lo", BLO, lo);
        check("branch_hi", {17'h0, BHI}, {17'h0, hi});
        check("irq", {31'h0, IRQ}, {31'h0, irq});
        @(posedge CLK);
    endtask
    // reads compare against d; one idle cycle keeps strobes from being assigned twice
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= w;
        RD <= !w;
        @(posedge CLK);
        WR <= 0;
        RD <= 0;
        #1;
        if (!w) begin
            check("rdata", RDATA, d);
        end
        @(posedge CLK);
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        bus(0, OFF_SLEEP_HI, 32'h7fff);
        bus(0, OFF_STAT_LO, RST_EN_LO);
        outs(RST_EN_LO, RST_EN_HI, 1'b0);
        bus(0, 8'h00, 32'h0);
        SLEEPING <= 1;
        r = xs();
        q = xs();
        bus(1, OFF_SLEEP_LO, q);
        bus(1, OFF_SLEEP_HI, r);
        bus(0, OFF_SLEEP_HI, {17'h0, r[14:0]});
        bus(1, OFF_STAT_HI, ~r);
        bus(0, OFF_STAT_HI, {17'h0, r[14:0]});
        bus(0, OFF_STAT_LO, q);
        outs(q, r[14:0], 1'b0);
        for (int i = 0; i < 8; i++) begin
            bus(1, OFF_INTERRUPT_MASK_ENABLE, xs() & 32'hfffffffe | i[0]);
            bus(1, OFF_INTERRUPT_FORCE, {31'h0, i[1]});
            RESUS_EVENT <= i[2];
            bus(1, OFF_INTERRUPT_MASKED_STATUS, xs());
            bus(0, OFF_INTERRUPT_MASK_ENABLE, {31'h0, i[0]});
            bus(0, OFF_RAW, {31'h0, i[2]});
            bus(0, OFF_INTERRUPT_MASKED_STATUS, {31'h0, exp_irq(i[2:0])});
            outs(q, r[14:0], exp_irq(i[2:0]));
        end
        SLEEPING <= 0;
        bus(1, OFF_WAKE_LO, r);
        bus(0, OFF_STAT_LO, r);
        outs(r, RST_EN_HI, 1'b1);
        CE <= 0;
        SLEEPING <= 1;
        bus(1, OFF_WAKE_LO, ~r);
        outs(r, RST_EN_HI, 1'b1);
        SLEEPING <= 0;
        CE <= 1;
        bus(0, OFF_WAKE_LO, r);
        RST <= 1;
        @(posedge CLK);
        RST <= 0;
        @(posedge CLK);
        bus(0, OFF_SLEEP_HI, 32'h7fff);
        bus(0, OFF_STAT_LO, RST_EN_LO);
        outs(RST_EN_LO, RST_EN_HI, 1'b0);
        stop_test();
    end
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule
bind cgs_clock_gate cgs_properties cgs_properties_i (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEPING(SLEEPING),
    .BRANCH_EN_LO(BRANCH_EN_LO), .BRANCH_EN_HI(BRANCH_EN_HI), .RESUS_IRQ(RESUS_IRQ));
